//--- logic/low_supply_monitor_pkg.sv
// Constants, field positions and state types of the low supply monitor control.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
package low_supply_monitor_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int ADDR_W = 4;
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0007;
  localparam logic [31:0] CTRL_WMASK = 32'hFFFF_F3E7;

  // ****************************************
  // Control fields
  // ****************************************
  localparam int THRESH_LSB = 0;
  localparam int THRESH_W = 3;
  localparam int MON_EN_BIT = 5;
  localparam int OUTCOME_BIT = 6;
  localparam int FILT_EN_BIT = 7;
  localparam int FCLK_LSB = 8;
  localparam int FALL_EN_BIT = 12;
  localparam int RISE_EN_BIT = 13;
  localparam int LEVEL_EN_BIT = 14;
  localparam int INT_EN_BIT = 15;
  localparam int FCOUNT_LSB = 16;
  localparam int FCOUNT_W = 16;

  // ****************************************
  // Status fields
  // ****************************************
  localparam int FLAG_BIT = 0;
  localparam int FILT_OUT_BIT = 1;
  localparam int RESET_PEND_BIT = 2;

  typedef enum logic [1:0] {
    FCLK_NONE = 2'b00,
    FCLK_BUS = 2'b01,
    FCLK_SLOW = 2'b10,
    FCLK_RSVD = 2'b11
  } filter_clock_t;

  typedef struct packed {
    logic [31:0] ctrl;
    logic event_flag;
    logic reset_pending;
    logic prev_filt;
    logic done;
    logic [31:0] readdata;
    logic [1:0] cmp_sync;
    logic [2:0] osc_sync;
  } monitor_state_t;

endpackage

//--- logic/sample_filter.sv
// Majority-free run-length filter: passes a new level once enough samples agree.
// Assumes din is already synchronous to ref_clk.
`timescale 1ns/100ps
module sample_filter
  import low_supply_monitor_pkg::*;
#(
  parameter int COUNT_W = FCOUNT_W
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic filter_on,
  input wire logic sample,
  input wire logic din,
  input wire logic [COUNT_W-1:0] filter_count,
  output logic dout
);

  typedef struct packed {
    logic [COUNT_W-1:0] cnt;
    logic out;
  } filter_state_t;

  filter_state_t q;
  filter_state_t next_q;
  logic [COUNT_W:0] cnt_plus;

  always_comb begin
    next_q = q;
    cnt_plus = {1'b0, q.cnt} + {{COUNT_W{1'b0}}, 1'b1};
    if (!filter_on) begin
      next_q.out = din;
      next_q.cnt = '0;
    end else if (sample) begin
      // No sample strobe means the output holds
      if (din == q.out) begin
        next_q.cnt = '0;
      end else if (cnt_plus >= {1'b0, filter_count}) begin
        next_q.out = din;
        next_q.cnt = '0;
      end else begin
        next_q.cnt = cnt_plus[COUNT_W-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      q <= '0;
    end else if (clk_en) begin
      q <= next_q;
    end
  end

  assign dout = q.out;

endmodule // sample_filter

//--- logic/low_supply_monitor.sv
// Digital control of the low supply monitor: bus registers, filter, triggers, outcome.
// Assumes an analog comparator output (high = supply below threshold) and a slow
// oscillator level, both asynchronous; Avalon-MM master on ref_clk.
`timescale 1ns/100ps
module low_supply_monitor
  import low_supply_monitor_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic comparator_below,
  input wire logic slow_internal_osc,
  input wire logic reset_clear,
  output logic [THRESH_W-1:0] threshold_select,
  output logic irq,
  output logic sys_reset_req
);

  // ****************************************
  // State
  // ****************************************
  monitor_state_t q;
  monitor_state_t next_q;
  logic filt;
  logic sample;
  logic accept_wr;
  logic ctrl_hit;
  logic status_hit;
  logic flag_clear;
  logic level_hit;
  logic rise_hit;
  logic fall_hit;
  logic trigger;
  logic [31:0] status_word;
  logic [31:0] be_mask;
  filter_clock_t fclk;

  assign fclk = filter_clock_t'(q.ctrl[FCLK_LSB +: 2]);

  // ****************************************
  // Sample strobe
  // ****************************************
  always_comb begin
    case (fclk)
      FCLK_BUS: sample = 1'b1;
      FCLK_SLOW: sample = q.osc_sync[1] & ~q.osc_sync[2];
      default: sample = 1'b0;
    endcase
  end

  sample_filter #(
    .COUNT_W(FCOUNT_W)
  ) u_filter (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .filter_on(q.ctrl[FILT_EN_BIT]),
    .sample(sample),
    .din(q.cmp_sync[1]),
    .filter_count(q.ctrl[FCOUNT_LSB +: FCOUNT_W]),
    .dout(filt)
  );

  // ****************************************
  // Bus decode
  // ****************************************
  always_comb begin
    ctrl_hit = 1'b0;
    status_hit = 1'b0;
    if (address == CTRL_OFFSET) begin
      ctrl_hit = 1'b1;
    end else if (address == STATUS_OFFSET) begin
      status_hit = 1'b1;
    end
  end

  // One wait state so read data always come from a register
  assign waitrequest = (read | write) & ~q.done;
  assign accept_wr = write & q.done;
  assign flag_clear = accept_wr & status_hit & byteenable[0] & ~writedata[FLAG_BIT];

  generate
    for (genvar b = 0; b < 4; b++) begin : g_be
      assign be_mask[8*b +: 8] = {8{byteenable[b]}};
    end
  endgenerate

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[FLAG_BIT] = q.event_flag;
    status_word[FILT_OUT_BIT] = filt;
    status_word[RESET_PEND_BIT] = q.reset_pending;
  end

  // ****************************************
  // Triggers
  // ****************************************
  assign level_hit = q.ctrl[LEVEL_EN_BIT] & filt;
  assign rise_hit = q.ctrl[RISE_EN_BIT] & filt & ~q.prev_filt;
  assign fall_hit = q.ctrl[FALL_EN_BIT] & ~filt & q.prev_filt;
  assign trigger = q.ctrl[MON_EN_BIT] & (level_hit | rise_hit | fall_hit);

  always_comb begin
    next_q = q;
    next_q.cmp_sync = {q.cmp_sync[0], comparator_below};
    next_q.osc_sync = {q.osc_sync[1:0], slow_internal_osc};
    next_q.prev_filt = filt;
    next_q.done = (read | write) & ~q.done;
    if (read & ~q.done) begin
      if (ctrl_hit) begin
        next_q.readdata = q.ctrl;
      end else if (status_hit) begin
        next_q.readdata = status_word;
      end else begin
        next_q.readdata = 32'h0000_0000;
      end
    end
    if (accept_wr & ctrl_hit) begin
      next_q.ctrl = (q.ctrl & ~(be_mask & CTRL_WMASK)) | (writedata & be_mask & CTRL_WMASK);
    end
    // Set wins over a clear in the same cycle
    // A pending flag simply stays set, so no second event is made until cleared
    next_q.event_flag = (q.event_flag & ~flag_clear)
      | (trigger & ~q.ctrl[OUTCOME_BIT]);
    next_q.reset_pending = (q.reset_pending & ~reset_clear)
      | (trigger & q.ctrl[OUTCOME_BIT]);
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      q <= '0;
      q.ctrl <= CTRL_RESET;
    end else if (clk_en) begin
      q <= next_q;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign readdata = q.readdata;
  assign threshold_select = q.ctrl[THRESH_LSB +: THRESH_W];
  assign irq = q.event_flag & q.ctrl[INT_EN_BIT] & ~q.ctrl[OUTCOME_BIT];
  assign sys_reset_req = q.reset_pending;

endmodule // low_supply_monitor

//--- testbench/supply_model.sv
// Stand-in for the analog comparator and the slow oscillator.
// Assumes the bench sets the comparator level on below_req.
`timescale 1ns/100ps
module supply_model (
  input wire logic ref_clk,
  input wire logic below_req,
  output logic comparator_below,
  output logic slow_internal_osc
);
  logic [2:0] div = 3'h0;
  // Runs free; eight bus clocks a period keep the run short
  always @(posedge ref_clk) div <= div + 3'h1;
  assign slow_internal_osc = div[2];
  assign comparator_below = below_req;
endmodule // supply_model

//--- testbench/low_supply_monitor_sva.sv
// Port checker of the low supply monitor control.
// Assumes one clock domain and clk_en held high.
`timescale 1ns/100ps
module low_supply_monitor_sva
  import low_supply_monitor_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic reset_clear,
  input wire logic [THRESH_W-1:0] threshold_select,
  input wire logic irq,
  input wire logic sys_reset_req
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  AST_EXCL: assert property (!(irq && sys_reset_req)) else $error("irq with reset");
  AST_THR_RST: assert property ($rose(resetn) |-> threshold_select == 3'h7)
    else $error("threshold reset");
  AST_OUT_RST: assert property ($rose(resetn) |-> !irq && !sys_reset_req)
    else $error("outputs after reset");
  AST_UNMAP: assert property (read && !waitrequest && address != CTRL_OFFSET
    && address != STATUS_OFFSET |-> readdata == 32'h0) else $error("unmapped read");
  AST_THR_WR: assert property (write && !waitrequest && address == CTRL_OFFSET
    && byteenable[0] |=> threshold_select == $past(writedata[2:0])) else $error("thr write");
  AST_HOLD: assert property (sys_reset_req && !reset_clear |=> sys_reset_req)
    else $error("reset dropped");
  AST_CLR: assert property ($fell(sys_reset_req) |-> $past(reset_clear))
    else $error("reset cleared alone");
  AST_FLAG: assert property (read && !waitrequest && address == STATUS_OFFSET
    && $past(irq) |-> readdata[FLAG_BIT]) else $error("flag lost");
endmodule // low_supply_monitor_sva

bind low_supply_monitor low_supply_monitor_sva chk (.ref_clk, .resetn, .address, .read,
  .write, .byteenable, .writedata, .readdata, .waitrequest, .reset_clear,
  .threshold_select, .irq, .sys_reset_req);

//--- testbench/low_supply_monitor_tb.sv
// Self-checking bench of the low supply monitor control.
// Assumes supply_model stands in for the analog comparator.
`timescale 1ns/100ps
module low_supply_monitor_tb;
  import low_supply_monitor_pkg::*;
  logic ref_clk = 1'b0, resetn = 1'b0, read = 1'b0, write = 1'b0;
  logic below_req = 1'b0, reset_clear = 1'b0;
  logic [ADDR_W-1:0] address = 4'h0;
  logic [31:0] writedata = 32'h0, readdata, rd;
  logic waitrequest, comparator_below, slow_internal_osc, irq, sys_reset_req;
  logic [THRESH_W-1:0] threshold_select;
  int error_cnt = 0, n_tests = 0;
  supply_model model (.ref_clk, .below_req, .comparator_below, .slow_internal_osc);
  low_supply_monitor dut (.ref_clk, .resetn, .clk_en(1'b1), .address, .read, .write,
    .byteenable(4'hF), .writedata, .readdata, .waitrequest, .comparator_below,
    .slow_internal_osc, .reset_clear, .threshold_select, .irq, .sys_reset_req);
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic results();
    $display("mismatches %0d of %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // Request stands until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    i = 0;
    do @(posedge ref_clk); while (waitrequest !== 1'b0 && ++i < 20);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(negedge ref_clk);
    if (i >= 20) begin
      error_cnt++;
      results();
    end
  endtask
  // Selects irq (0) or sys_reset_req (1); avoids passing a port net by reference
  task automatic wait_on(input bit sel);
    int i;
    for (i = 0; i < 300 && (sel ? sys_reset_req : irq) !== 1'b1; i++) @(negedge ref_clk);
    if (i >= 300) begin
      error_cnt++;
      results();
    end
  endtask
  task automatic set_below(input logic v);
    @(posedge ref_clk);
    below_req <= v;
  endtask
  task automatic cfg(input logic [31:0] v);
    bus(1'b1, CTRL_OFFSET, v & ~32'h20);
    bus(1'b1, CTRL_OFFSET, v);
  endtask
  task automatic t_regs();
    int c;
    chk("thr", 32'h7, 32'(threshold_select));
    bus(1'b0, CTRL_OFFSET, 32'h0);
    chk("ctrl", 32'h7, rd);
    bus(1'b0, STATUS_OFFSET, 32'h0);
    chk("stat", 32'h0, rd);
    bus(1'b1, 4'h8, 32'hFFFF_FFFF);
    bus(1'b0, 4'h8, 32'h0);
    chk("hole", 32'h0, rd);
    bus(1'b1, CTRL_OFFSET, 32'hFFFF_F8DF);
    bus(1'b0, CTRL_OFFSET, 32'h0);
    chk("ctrl", 32'hFFFF_F0C7, rd);
    for (c = 0; c < 8; c++) begin
      bus(1'b1, CTRL_OFFSET, c);
      chk("thr", c, 32'(threshold_select));
    end
  endtask
  task automatic t_level();
    cfg(32'h0000_4027);
    set_below(1'b1);
    repeat (8) @(negedge ref_clk);
    chk("masked", 32'h0, 32'(irq));
    cfg(32'h0000_C027);
    wait_on(1'b0);
    bus(1'b0, STATUS_OFFSET, 32'h0);
    chk("flag", 32'h1, 32'(rd[FLAG_BIT]));
    chk("rst", 32'h0, 32'(sys_reset_req));
    set_below(1'b0);
    bus(1'b1, STATUS_OFFSET, 32'h1);
    chk("w1", 32'h1, 32'(irq));
    bus(1'b1, STATUS_OFFSET, 32'h0);
    chk("w0", 32'h0, 32'(irq));
  endtask
  task automatic t_gate();
    cfg(32'h0000_A0A7);
    set_below(1'b1);
    repeat (10) @(negedge ref_clk);
    chk("no clk", 32'h0, 32'(irq));
    bus(1'b1, CTRL_OFFSET, 32'h0000_C007);
    repeat (10) @(negedge ref_clk);
    chk("off", 32'h0, 32'(irq));
    set_below(1'b0);
    repeat (6) @(negedge ref_clk);
  endtask
  task automatic t_filter();
    cfg(32'h0005_A1A7);
    set_below(1'b1);
    repeat (3) @(posedge ref_clk);
    below_req <= 1'b0;
    repeat (12) @(negedge ref_clk);
    chk("pulse", 32'h0, 32'(irq));
    set_below(1'b1);
    wait_on(1'b0);
    bus(1'b1, STATUS_OFFSET, 32'h0);
    repeat (12) @(negedge ref_clk);
    chk("edge once", 32'h0, 32'(irq));
    cfg(32'h0005_91A7);
    set_below(1'b0);
    wait_on(1'b0);
    bus(1'b1, STATUS_OFFSET, 32'h0);
  endtask
  task automatic t_reset_mode();
    cfg(32'h0002_42E7);
    set_below(1'b1);
    wait_on(1'b1);
    chk("int", 32'h0, 32'(irq));
    set_below(1'b0);
    repeat (60) @(negedge ref_clk);
    chk("held", 32'h1, 32'(sys_reset_req));
    @(posedge ref_clk);
    reset_clear <= 1'b1;
    @(posedge ref_clk);
    reset_clear <= 1'b0;
    repeat (3) @(negedge ref_clk);
    chk("clr", 32'h0, 32'(sys_reset_req));
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    t_regs();
    t_level();
    t_gate();
    t_filter();
    t_reset_mode();
    results();
  end
endmodule // low_supply_monitor_tb
